// ---- pkg/spi_eeprom_pkg.sv ----
package spi_eeprom_pkg;

	// ------------------------------------------------------------
	// pin groups
	// ------------------------------------------------------------
	typedef struct packed {
		logic sck;
		logic select_n;
		logic serial_in;
		logic suspend_n;
		logic write_protect_n;
	} pins_type;

	typedef struct packed {
		logic sck_rise;
		logic sck_fall;
		logic sel_rise;
		logic wp_fall;
	} edge_type;

	// pin levels held in the sampler while in reset
	localparam pins_type PINS_RESET = '{sck: 1'b0, select_n: 1'b1, serial_in: 1'b0,
		suspend_n: 1'b1, write_protect_n: 1'b1};

	// ------------------------------------------------------------
	// instruction codes
	// ------------------------------------------------------------
	localparam logic [7:0] OP_WRSR = 8'h01;
	localparam logic [7:0] OP_WRITE = 8'h02;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_WRDI = 8'h04;
	localparam logic [7:0] OP_RDSR = 8'h05;
	localparam logic [7:0] OP_WREN = 8'h06;

	// ------------------------------------------------------------
	// status byte layout and reset values
	// ------------------------------------------------------------
	localparam int SR_BUSY_BIT = 0;
	localparam int SR_WEL_BIT = 1;
	localparam int SR_BP_LSB = 2;
	localparam int SR_PEN_BIT = 7;
	localparam logic PEN_RESET = 1'b0;
	localparam logic [1:0] BP_RESET = 2'h0;
	localparam logic [1:0] BP_NONE = 2'h0;
	localparam logic [1:0] BP_QUARTER = 2'h1;
	localparam logic [1:0] BP_HALF = 2'h2;

	// ------------------------------------------------------------
	// array size and timing
	// ------------------------------------------------------------
	localparam int ARRAY_ADDR_W = 14;
	localparam int CLK_PERIOD_NS = 25;
	localparam int WRITE_TIME_MS = 5;
	// longest time: rounds down to whole cycles
	localparam int WRITE_CYCLES = (WRITE_TIME_MS * 1000000) / CLK_PERIOD_NS;

	// ------------------------------------------------------------
	// shift engine states, gray along opcode-address-data in path (st_addr_lo to st_data_out flips two bits)
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		st_opcode = 3'h0,
		st_addr_hi = 3'h1,
		st_addr_lo = 3'h3,
		st_data_in = 3'h2,
		st_data_out = 3'h6,
		st_status_in = 3'h7,
		st_ignore = 3'h5
	} state_type;

endpackage : spi_eeprom_pkg

// ---- logic/pin_sampler.sv ----
`timescale 1ns/1ps
module pin_sampler
	import spi_eeprom_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire pins_type pins,
	output pins_type sampled,
	output edge_type events
);

	pins_type stage_reg, stage_next;
	pins_type prev_reg, prev_next;

	// ------------------------------------------------------------
	// pin registers
	// ------------------------------------------------------------
	// capture pins, keep one older copy for edge detection
	always_comb begin
		stage_next = pins;
		prev_next = stage_reg;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stage_reg <= PINS_RESET;
			prev_reg <= PINS_RESET;
		end else begin
			stage_reg <= stage_next;
			prev_reg <= prev_next;
		end
	end

	// edge events, one cycle each
	assign sampled = stage_reg;
	assign events.sck_rise = stage_reg.sck & ~prev_reg.sck;
	assign events.sck_fall = ~stage_reg.sck & prev_reg.sck;
	assign events.sel_rise = stage_reg.select_n & ~prev_reg.select_n;
	assign events.wp_fall = ~stage_reg.write_protect_n & prev_reg.write_protect_n;

endmodule : pin_sampler

// ---- logic/eeprom_array.sv ----
`timescale 1ns/1ps
module eeprom_array #(
	parameter int ADDR_W = 14,
	parameter int DATA_W = 8
) (
	input wire logic clk,
	input wire logic wr_en,
	input wire logic [ADDR_W-1:0] wr_addr,
	input wire logic [DATA_W-1:0] wr_data,
	input wire logic [ADDR_W-1:0] rd_addr,
	output logic [DATA_W-1:0] rd_data
);

	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	// byte write at the end of a nonvolatile cycle
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// read is combinational, caught by the shifter on load
	assign rd_data = mem[rd_addr];

endmodule : eeprom_array

// ---- logic/spi_eeprom_pin_control.sv ----
`timescale 1ns/1ps
module spi_eeprom_pin_control
	import spi_eeprom_pkg::*;
#(
	parameter int ADDR_W = ARRAY_ADDR_W,
	parameter int WRITE_CYCLES_P = WRITE_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic sck,
	input wire logic select_n,
	input wire logic serial_in,
	input wire logic suspend_n,
	input wire logic write_protect_n,
	output logic serial_out,
	output logic serial_out_oe_n,
	output logic write_busy
);

	localparam int TMR_W = $clog2(WRITE_CYCLES_P + 1);
	localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(WRITE_CYCLES_P - 1);

	// ------------------------------------------------------------
	// block protect decode
	// ------------------------------------------------------------
	// true when the address falls in the protected upper quarter, upper half or, for bp 3, anywhere
	function automatic logic is_protected(input logic [ADDR_W-1:0] a, input logic [1:0] bp);
		logic r;
		r = 1'b0;
		case (bp)
			BP_NONE: r = 1'b0;
			BP_QUARTER: r = (a[ADDR_W-1 -: 2] == 2'h3);
			BP_HALF: r = a[ADDR_W-1];
			default: r = 1'b1;
		endcase
		return r;
	endfunction : is_protected

	// ------------------------------------------------------------
	// pins and array
	// ------------------------------------------------------------
	pins_type pins_in, pin;
	edge_type ev;
	logic [7:0] rd_data;
	logic mem_we_reg, mem_we_next;
	logic [ADDR_W-1:0] cyc_addr_reg, cyc_addr_next;
	logic [7:0] cyc_data_reg, cyc_data_next;
	logic [15:0] addr_reg, addr_next;

	assign pins_in = '{sck: sck, select_n: select_n, serial_in: serial_in,
		suspend_n: suspend_n, write_protect_n: write_protect_n};

	pin_sampler u_sampler (
		.clk(clk),
		.rst(rst),
		.pins(pins_in),
		.sampled(pin),
		.events(ev)
	);

	eeprom_array #(
		.ADDR_W(ADDR_W),
		.DATA_W(8)
	) u_array (
		.clk(clk),
		.wr_en(mem_we_reg),
		.wr_addr(cyc_addr_reg),
		.wr_data(cyc_data_reg),
		.rd_addr(addr_reg[ADDR_W-1:0]),
		.rd_data(rd_data)
	);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	state_type state_reg, state_next;
	logic [2:0] bit_cnt_reg, bit_cnt_next;
	logic [7:0] in_shift_reg, in_shift_next;
	logic [7:0] opcode_reg, opcode_next;
	logic [7:0] wdata_reg, wdata_next;
	logic wr_pend_reg, wr_pend_next;
	logic [7:0] sr_val_reg, sr_val_next;
	logic sr_pend_reg, sr_pend_next;
	logic sr_abort_reg, sr_abort_next;
	logic paused_reg, paused_next;
	logic [7:0] out_shift_reg, out_shift_next;
	logic [2:0] out_cnt_reg, out_cnt_next;
	logic driving_reg, driving_next;
	logic so_reg, so_next;
	logic oe_n_reg, oe_n_next;
	logic pen_reg, pen_next;
	logic [1:0] bp_reg, bp_next;
	logic wel_reg, wel_next;
	logic busy_reg, busy_next;
	logic cyc_sr_reg, cyc_sr_next;
	logic [7:0] cyc_sr_val_reg, cyc_sr_val_next;
	logic [TMR_W-1:0] timer_reg, timer_next;

	logic sel, act_rise, act_fall;
	logic [7:0] new_byte, status_byte;

	assign sel = ~pin.select_n;
	// edges count only while selected and not paused
	assign act_rise = ev.sck_rise & sel & ~paused_reg;
	assign act_fall = ev.sck_fall & sel & ~paused_reg;
	assign new_byte = {in_shift_reg[6:0], pin.serial_in};
	assign status_byte = {pen_reg, 3'h0, bp_reg, wel_reg, busy_reg};

	// ------------------------------------------------------------
	// pause control
	// ------------------------------------------------------------
	// suspend_n acts only while the clock is low
	always_comb begin
		paused_next = paused_reg;
		if (!sel) begin
			paused_next = 1'b0;
		end else if (!paused_reg && !pin.suspend_n && !pin.sck) begin
			paused_next = 1'b1;
		end else if (paused_reg && pin.suspend_n && !pin.sck) begin
			paused_next = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			paused_reg <= 1'b0;
		end else begin
			paused_reg <= paused_next;
		end
	end

	// ------------------------------------------------------------
	// serial engine and write cycle
	// ------------------------------------------------------------
	// decodes bytes, drives the output shifter, runs the write timer
	always_comb begin
		state_next = state_reg;
		bit_cnt_next = bit_cnt_reg;
		in_shift_next = in_shift_reg;
		opcode_next = opcode_reg;
		addr_next = addr_reg;
		wdata_next = wdata_reg;
		wr_pend_next = wr_pend_reg;
		sr_val_next = sr_val_reg;
		sr_pend_next = sr_pend_reg;
		sr_abort_next = sr_abort_reg;
		out_shift_next = out_shift_reg;
		out_cnt_next = out_cnt_reg;
		driving_next = driving_reg;
		pen_next = pen_reg;
		bp_next = bp_reg;
		wel_next = wel_reg;
		busy_next = busy_reg;
		cyc_sr_next = cyc_sr_reg;
		cyc_sr_val_next = cyc_sr_val_reg;
		cyc_addr_next = cyc_addr_reg;
		cyc_data_next = cyc_data_reg;
		timer_next = timer_reg;
		mem_we_next = 1'b0;
		// self-timed cycle, no outside timing involved
		if (busy_reg) begin
			if (timer_reg == TMR_LAST) begin
				busy_next = 1'b0;
				wel_next = 1'b0;
				timer_next = '0;
				if (cyc_sr_reg) begin
					pen_next = cyc_sr_val_reg[SR_PEN_BIT];
					bp_next = cyc_sr_val_reg[SR_BP_LSB +: 2];
				end else begin
					mem_we_next = 1'b1;
				end
			end else begin
				timer_next = timer_reg + 1'b1;
			end
		end
		// protect pin falling while a status write is still open
		if (sel && (state_reg == st_status_in || sr_pend_reg) && pen_reg && ev.wp_fall) begin
			sr_abort_next = 1'b1;
		end
		if (ev.sel_rise) begin
			// end of instruction: commit and return to idle
			state_next = st_opcode;
			bit_cnt_next = '0;
			out_cnt_next = '0;
			driving_next = 1'b0;
			sr_pend_next = 1'b0;
			sr_abort_next = 1'b0;
			wr_pend_next = 1'b0;
			if (sr_pend_reg && wel_reg && !busy_reg && !sr_abort_reg
				&& !(pen_reg && !pin.write_protect_n)) begin
				busy_next = 1'b1;
				cyc_sr_next = 1'b1;
				cyc_sr_val_next = sr_val_reg;
				timer_next = '0;
			end else if (wr_pend_reg && wel_reg && !busy_reg
				&& !is_protected(addr_reg[ADDR_W-1:0], bp_reg)) begin
				busy_next = 1'b1;
				cyc_sr_next = 1'b0;
				cyc_addr_next = addr_reg[ADDR_W-1:0];
				cyc_data_next = wdata_reg;
				timer_next = '0;
			end
		end else if (act_rise) begin
			in_shift_next = new_byte;
			bit_cnt_next = bit_cnt_reg + 1'b1;
			if (bit_cnt_reg == 3'h7) begin
				case (state_reg)
					st_opcode: begin
						opcode_next = new_byte;
						state_next = st_ignore;
						case (new_byte)
							OP_WREN: wel_next = busy_reg ? wel_reg : 1'b1;
							OP_WRDI: wel_next = busy_reg ? wel_reg : 1'b0;
							OP_RDSR: state_next = st_data_out;
							OP_WRSR: state_next = busy_reg ? st_ignore : st_status_in;
							OP_READ: state_next = busy_reg ? st_ignore : st_addr_hi;
							OP_WRITE: state_next = busy_reg ? st_ignore : st_addr_hi;
							default: state_next = st_ignore;
						endcase
					end
					st_addr_hi: begin
						addr_next[15:8] = new_byte;
						state_next = st_addr_lo;
					end
					st_addr_lo: begin
						addr_next[7:0] = new_byte;
						state_next = (opcode_reg == OP_READ) ? st_data_out : st_data_in;
					end
					st_data_in: begin
						// single byte buffer, a later byte replaces it
						wdata_next = new_byte;
						wr_pend_next = 1'b1;
					end
					st_status_in: begin
						sr_val_next = new_byte;
						sr_pend_next = 1'b1;
						state_next = st_ignore;
					end
					st_data_out: state_next = st_data_out;
					st_ignore: state_next = st_ignore;
					default: state_next = st_ignore;
				endcase
			end
		end else if (act_fall && state_reg == st_data_out) begin
			// load a new byte after the eighth bit, else shift
			driving_next = 1'b1;
			if (out_cnt_reg == 3'h0) begin
				out_cnt_next = 3'h7;
				if (opcode_reg == OP_RDSR) begin
					out_shift_next = status_byte;
				end else begin
					out_shift_next = rd_data;
					addr_next = addr_reg + 16'h0001;
				end
			end else begin
				out_cnt_next = out_cnt_reg - 1'b1;
				out_shift_next = {out_shift_reg[6:0], 1'b0};
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= st_opcode;
			bit_cnt_reg <= '0;
			in_shift_reg <= '0;
			opcode_reg <= '0;
			addr_reg <= '0;
			wdata_reg <= '0;
			wr_pend_reg <= 1'b0;
			sr_val_reg <= '0;
			sr_pend_reg <= 1'b0;
			sr_abort_reg <= 1'b0;
			out_shift_reg <= '0;
			out_cnt_reg <= '0;
			driving_reg <= 1'b0;
			pen_reg <= PEN_RESET;
			bp_reg <= BP_RESET;
			wel_reg <= 1'b0;
			busy_reg <= 1'b0;
			cyc_sr_reg <= 1'b0;
			cyc_sr_val_reg <= '0;
			cyc_addr_reg <= '0;
			cyc_data_reg <= '0;
			timer_reg <= '0;
			mem_we_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			bit_cnt_reg <= bit_cnt_next;
			in_shift_reg <= in_shift_next;
			opcode_reg <= opcode_next;
			addr_reg <= addr_next;
			wdata_reg <= wdata_next;
			wr_pend_reg <= wr_pend_next;
			sr_val_reg <= sr_val_next;
			sr_pend_reg <= sr_pend_next;
			sr_abort_reg <= sr_abort_next;
			out_shift_reg <= out_shift_next;
			out_cnt_reg <= out_cnt_next;
			driving_reg <= driving_next;
			pen_reg <= pen_next;
			bp_reg <= bp_next;
			wel_reg <= wel_next;
			busy_reg <= busy_next;
			cyc_sr_reg <= cyc_sr_next;
			cyc_sr_val_reg <= cyc_sr_val_next;
			cyc_addr_reg <= cyc_addr_next;
			cyc_data_reg <= cyc_data_next;
			timer_reg <= timer_next;
			mem_we_reg <= mem_we_next;
		end
	end

	// ------------------------------------------------------------
	// output pins
	// ------------------------------------------------------------
	// drive only while selected, unpaused and shifting out
	always_comb begin
		so_next = out_shift_next[7];
		oe_n_next = ~(sel && !paused_next && driving_next && !ev.sel_rise);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			so_reg <= 1'b0;
			oe_n_reg <= 1'b1;
		end else begin
			so_reg <= so_next;
			oe_n_reg <= oe_n_next;
		end
	end

	assign serial_out = so_reg;
	assign serial_out_oe_n = oe_n_reg;
	assign write_busy = busy_reg;

endmodule : spi_eeprom_pin_control

// ---- tb/spi_eeprom_pin_control_sva.sv ----
`timescale 1ns/1ps
module spi_eeprom_pin_control_sva
	import spi_eeprom_pkg::*;
#(
	parameter int ADDR_W = ARRAY_ADDR_W,
	parameter int WRITE_CYCLES_P = WRITE_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic sck,
	input wire logic select_n,
	input wire logic serial_in,
	input wire logic suspend_n,
	input wire logic write_protect_n,
	input wire logic serial_out,
	input wire logic serial_out_oe_n,
	input wire logic write_busy
);
	// ------------------------------------------------------------
	// write cycle length counter
	// ------------------------------------------------------------
	int busy_cnt_reg;
	int busy_cnt_next;
	always_comb begin
		busy_cnt_next = write_busy ? busy_cnt_reg + 1 : 0;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) busy_cnt_reg <= 0;
		else busy_cnt_reg <= busy_cnt_next;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// ------------------------------------------------------------
	// pin checks
	// ------------------------------------------------------------
	desel_hiz_a: assert property (select_n [*3] |=> serial_out_oe_n)
		else $error("output driven while deselected");
	sel_drive_a: assert property (!serial_out_oe_n |-> !$past(select_n, 2) || !$past(select_n, 3))
		else $error("output driven without select");
	desel_release_a: assert property ($rose(select_n) |-> ##[1:3] serial_out_oe_n)
		else $error("output not released after deselect");
	pause_hiz_a: assert property ((!suspend_n && !sck) ##1 !suspend_n [*3] |=> serial_out_oe_n)
		else $error("output driven while paused");
	shift_fall_a: assert property (!serial_out_oe_n && !$past(serial_out_oe_n) && $changed(serial_out)
		|-> !$past(sck, 1) && !$past(sck, 2))
		else $error("output bit changed outside falling edge");
	high_stable_a: assert property (!serial_out_oe_n && sck && $past(sck, 1) && $past(sck, 2)
		|-> $stable(serial_out))
		else $error("output bit moved while clock high");
	busy_len_a: assert property ($fell(write_busy) |-> busy_cnt_reg == WRITE_CYCLES_P)
		else $error("write cycle length wrong");
	busy_bound_a: assert property (write_busy |-> busy_cnt_reg < WRITE_CYCLES_P)
		else $error("write cycle too long");
	commit_desel_a: assert property ($rose(write_busy) |-> $past(select_n, 1) && select_n)
		else $error("write started while selected");
	busy_cov: cover property ($rose(write_busy));
	drive_cov: cover property ($fell(serial_out_oe_n));
	pause_cov: cover property ((!suspend_n && !sck) ##1 !suspend_n [*3]);
	wp_late_cov: cover property (write_busy && $fell(write_protect_n));
	paused_data_cov: cover property (!suspend_n && sck && $changed(serial_in));
endmodule : spi_eeprom_pin_control_sva

bind spi_eeprom_pin_control spi_eeprom_pin_control_sva #(.ADDR_W(ADDR_W),
	.WRITE_CYCLES_P(WRITE_CYCLES_P)) chk_u (.clk(clk), .rst(rst), .sck(sck),
	.select_n(select_n), .serial_in(serial_in), .suspend_n(suspend_n),
	.write_protect_n(write_protect_n), .serial_out(serial_out),
	.serial_out_oe_n(serial_out_oe_n), .write_busy(write_busy));

// ---- tb/spi_master_model.sv ----
`timescale 1ns/1ps
module spi_master_model (
	input wire logic clk,
	input wire logic serial_out,
	output logic sck,
	output logic select_n,
	output logic serial_in,
	output logic suspend_n
);
	// ------------------------------------------------------------
	// master state
	// ------------------------------------------------------------
	localparam int HALF = 4; // clock phase of four system clocks
	logic cpol = 1'b0;
	int pause_bit = -1;
	int nbit = 0;
	// idle pins at time zero
	initial begin
		sck = 1'b0;
		select_n = 1'b1;
		serial_in = 1'b0;
		suspend_n = 1'b1;
	end
	// ------------------------------------------------------------
	// frame tasks
	// ------------------------------------------------------------
	task automatic sel();
		@(posedge clk);
		sck <= cpol;
		repeat (HALF) @(posedge clk);
		select_n <= 1'b0;
		nbit = 0;
		repeat (HALF) @(posedge clk);
	endtask : sel
	task automatic desel();
		sck <= cpol;
		repeat (HALF) @(posedge clk);
		select_n <= 1'b1;
		@(posedge clk);
	endtask : desel
	// pause with clock low, toggle clock and data meanwhile
	task automatic pause_gap();
		suspend_n <= 1'b0;
		repeat (HALF) @(posedge clk);
		repeat (3) begin
			sck <= 1'b1;
			serial_in <= ~serial_in;
			repeat (HALF) @(posedge clk);
			sck <= 1'b0;
			repeat (HALF) @(posedge clk);
		end
		suspend_n <= 1'b1;
		repeat (HALF) @(posedge clk);
	endtask : pause_gap
	// one byte, msb first; read bit taken at the rising edge
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			sck <= 1'b0;
			repeat (HALF) @(posedge clk);
			if (nbit == pause_bit) pause_gap();
			serial_in <= tx[i];
			repeat (HALF) @(posedge clk);
			rx[i] = serial_out;
			sck <= 1'b1;
			repeat (HALF) @(posedge clk);
			nbit++;
		end
	endtask : xfer
endmodule : spi_master_model

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench;
	import spi_eeprom_pkg::*;
	// ------------------------------------------------------------
	// signals and instances
	// ------------------------------------------------------------
	localparam int WC = 20;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic write_protect_n = 1'b1;
	logic sck, select_n, serial_in, suspend_n, serial_out, serial_out_oe_n, write_busy;
	logic so_last = 1'b0;
	logic so_line;
	int n_mismatch = 0;
	int checks = 0;
	int cycles = 0;
	int wp_event = 0;
	logic [15:0] corner [3] = '{16'h3000, 16'h2000, 16'h0000};
	logic [7:0] old [3];
	always #12.5 clk = ~clk;
	// released data line holds the inverse of the last driven bit
	assign so_line = (serial_out_oe_n === 1'b0) ? serial_out : ~so_last;
	always @(posedge clk) begin
		if (serial_out_oe_n === 1'b0) so_last <= serial_out;
		cycles++;
		if (cycles == 40000) begin
			n_mismatch++;
			close_out();
		end
	end
	spi_eeprom_pin_control #(.WRITE_CYCLES_P(WC)) dut_u (.clk(clk), .rst(rst), .sck(sck),
		.select_n(select_n), .serial_in(serial_in), .suspend_n(suspend_n),
		.write_protect_n(write_protect_n), .serial_out(serial_out),
		.serial_out_oe_n(serial_out_oe_n), .write_busy(write_busy));
	spi_master_model m_u (.clk(clk), .serial_out(so_line), .sck(sck), .select_n(select_n),
		.serial_in(serial_in), .suspend_n(suspend_n));
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : close_out
	// one framed instruction, then count the write cycle
	task automatic txn(input logic [7:0] op, input logic [23:0] arg, input int nb, input int wlen,
		output logic [7:0] rx);
		int n;
		n = 0;
		m_u.sel();
		m_u.xfer(op, rx);
		if (wp_event == 1 && op == OP_WRSR) begin
			write_protect_n <= 1'b0;
			repeat (4) @(posedge clk);
			write_protect_n <= 1'b1;
		end
		for (int i = nb - 1; i >= 0; i--) m_u.xfer(arg[8*i +: 8], rx);
		m_u.desel();
		repeat (WC + 16) begin
			@(posedge clk);
			if (write_busy === 1'b1) n++;
			if (wp_event == 2 && n == 3) write_protect_n <= 1'b0;
		end
		if (wlen >= 0) check("busy cycles", n[7:0], wlen[7:0]);
	endtask : txn
	task automatic wrsr(input logic [7:0] v, input int wlen);
		logic [7:0] rx;
		txn(OP_WREN, 24'h0, 0, 0, rx);
		txn(OP_WRSR, {16'h0, v}, 1, wlen, rx);
	endtask : wrsr
	task automatic st(input string name, input logic [7:0] exp);
		logic [7:0] rx;
		txn(OP_RDSR, 24'h0, 1, 0, rx);
		check(name, rx & 8'h8C, exp);
		$display("test %s done", name);
	endtask : st
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		logic [7:0] rx;
		logic [15:0] a;
		logic [7:0] d;
		void'($urandom(65889));
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		wrsr(8'h8C, WC);
		st("status_write", 8'h8C);
		write_protect_n <= 1'b0;
		wrsr(8'h00, 0);
		write_protect_n <= 1'b1;
		st("pin_locked", 8'h8C);
		wp_event = 1;
		wrsr(8'h00, 0);
		st("mid_abort", 8'h8C);
		wp_event = 2;
		wrsr(8'h80, WC);
		wp_event = 0;
		write_protect_n <= 1'b1;
		st("late_fall", 8'h80);
		wrsr(8'h00, WC);
		write_protect_n <= 1'b0;
		wrsr(8'h08, WC);
		write_protect_n <= 1'b1;
		st("pin_ignored", 8'h08);
		wrsr(8'h00, WC);
		// random bytes in both modes, some paused mid byte
		for (int i = 0; i < 6; i++) begin
			m_u.cpol = i[0];
			m_u.pause_bit = i[1] ? 28 : -1;
			a = (i < 3) ? corner[i] : {2'b00, 14'($urandom)};
			d = 8'($urandom);
			if (i < 3) old[i] = d;
			txn(OP_WREN, 24'h0, 0, 0, rx);
			txn(OP_WRITE, {a, d}, 3, WC, rx);
			txn(OP_READ, {a, 8'h00}, 3, 0, rx);
			check("read data", rx, d);
		end
		m_u.pause_bit = -1;
		$display("test random_rw done");
		// each protected range keeps its old byte
		for (int k = 1; k <= 3; k++) begin
			wrsr(8'(k << 2), WC);
			txn(OP_WREN, 24'h0, 0, 0, rx);
			txn(OP_WRITE, {corner[k-1], ~old[k-1]}, 3, 0, rx);
			txn(OP_READ, {corner[k-1], 8'h00}, 3, 0, rx);
			check("protected byte", rx, old[k-1]);
		end
		wrsr(8'h00, WC);
		$display("test block_protect done");
		// a disable between enable and status write leaves the latch clear
		txn(OP_WREN, 24'h0, 0, 0, rx);
		txn(OP_WRDI, 24'h0, 0, 0, rx);
		txn(OP_WRSR, 24'h0C, 1, 0, rx);
		// bits while deselected are ignored, a partial instruction is dropped
		m_u.xfer(OP_WREN, rx);
		txn(OP_WRSR, 24'h0C, 1, 0, rx);
		m_u.sel();
		m_u.xfer(OP_READ, rx);
		m_u.desel();
		st("deselect", 8'h00);
		close_out();
	end
endmodule : testbench
